//--- core/pkg_cfg_pkg.sv
// package: indices, parameter codes, field positions and completion codes
package pkg_cfg_pkg;
    localparam logic [7:0]  IDX_PKG_ID        = 8'h00;
    localparam logic [7:0]  IDX_LIMIT1        = 8'h1A;
    localparam logic [7:0]  IDX_LIMIT2        = 8'h1B;
    localparam logic [7:0]  IDX_SKU_LO        = 8'h1C;
    localparam logic [7:0]  IDX_SKU_HI        = 8'h1D;
    localparam logic [7:0]  IDX_UNITS         = 8'h1E;
    localparam logic [7:0]  IDX_RUN_TIME      = 8'h1F;
    localparam logic [7:0]  IDX_THROTTLE_TIME = 8'h20;
    localparam logic [15:0] PARAM_ZERO        = 16'h0000;
    localparam logic [15:0] PARAM_PROC_ID     = 16'h0000;
    localparam logic [15:0] PARAM_PLATFORM_ID = 16'h0001;
    localparam logic [15:0] PARAM_THREAD_CNT  = 16'h0003;
    localparam logic [15:0] PARAM_UCODE_REV   = 16'h0004;
    localparam logic [15:0] PARAM_ERR_LOG     = 16'h0005;
    localparam logic [7:0]  CC_OK             = 8'h40;
    localparam logic [7:0]  CC_BAD_PARAM      = 8'h90;
    localparam logic [7:0]  CC_BAD_REQ        = 8'h91;
    // processor identification word layout
    localparam int STEP_LSB = 0;
    localparam int MODEL_LSB = 4;
    localparam int FAMILY_LSB = 8;
    localparam int TYPE_LSB = 12;
    localparam int EXT_MODEL_LSB = 16;
    localparam int EXT_FAMILY_LSB = 20;
    // unit word layout
    localparam int POWER_UNIT_LSB = 0;
    localparam int ENERGY_UNIT_LSB = 8;
    localparam int TIME_UNIT_LSB = 16;
    localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
    // one millisecond of run time at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int MS_US = 1000;
    localparam int MS_CYCLES = CLK_MHZ * MS_US;
endpackage

//--- core/ms_tick_if.sv
// interface: millisecond tick carried from the timer to the decoder
`timescale 1ns/1ps
interface ms_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

//--- core/ms_tick_gen.sv
// module: free-running millisecond tick generator
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter int PERIOD = pkg_cfg_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // tick out
    ms_tick_if.src    tick_out
);
    logic [31:0] count_r;

    // count one period then pulse
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            count_r <= 32'h0000_0000;
        else if (count_r == 32'(PERIOD - 1))
            count_r <= 32'h0000_0000;
        else
            count_r <= count_r + 32'h0000_0001;
    end

    assign tick_out.tick = (count_r == 32'(PERIOD - 1));
endmodule // ms_tick_gen

//--- core/pkg_config_service_decoder.sv
// module: package configuration read/write service dispatcher
//
// Overview of operation
// R1 - index 26/27 param 0 access power limits
// R2 - index 28/29 return low/high product power
// R3 - index 30 returns time, energy, power units
// R4 - index 31 returns millisecond run time
// R5 - index 32 returns thermal throttle time
// R6 - index 0 parameter selects identification item
// R7 - processor id word packs documented field layout
// R8 - platform id carries three-bit processor flag
// R9 - thread count in bits 3..0, rest zero
// R10 - thread count fixed by product core count
// R11 - index 0 parameters 0,1,3,4,5 select items
// R12 - microcode revision is one 32-bit value
// R13 - out-of-range parameter answers code 0x90
// R14 - unknown index or bad write: error, no change
`timescale 1ns/1ps
module pkg_config_service_decoder #(
    parameter int          MS_PERIOD    = pkg_cfg_pkg::MS_CYCLES,
    parameter logic [3:0]  STEP_VAL     = 4'h1,
    parameter logic [3:0]  MODEL_VAL    = 4'h2,
    parameter logic [3:0]  FAMILY_VAL   = 4'h3,
    parameter logic [1:0]  TYPE_VAL     = 2'h0,
    parameter logic [3:0]  EXT_MODEL_VAL = 4'h4,
    parameter logic [7:0]  EXT_FAM_VAL  = 8'h00,
    parameter logic [2:0]  PROC_FLAG    = 3'h1,
    parameter logic [3:0]  THREAD_COUNT = 4'h8,
    parameter logic [31:0] UCODE_REV    = 32'h0000_0001, // arbitrary value
    parameter logic [3:0]  POWER_UNIT   = 4'h3,
    parameter logic [4:0]  ENERGY_UNIT  = 5'h10,
    parameter logic [3:0]  TIME_UNIT    = 4'hA
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // request
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [7:0]  req_index,
    input  wire logic [15:0] req_param,
    input  wire logic [31:0] req_wdata,
    // response
    output logic             rsp_valid,
    output logic [7:0]       rsp_code,
    output logic [31:0]      rsp_rdata,
    // device state inputs
    input  wire logic [63:0] product_power,
    input  wire logic        thermal_throttle_circuit,
    input  wire logic [31:0] err_src_log,
    // power limit outputs
    output logic [31:0]      power_limit1,
    output logic [31:0]      power_limit2
);
    ms_tick_if   ms_tick();
    logic [31:0] run_ms_r;
    logic [31:0] throttle_ms_r;
    logic [31:0] limit1_r;
    logic [31:0] limit2_r;
    logic        rsp_valid_r;
    logic [7:0]  rsp_code_r;
    logic [31:0] rsp_rdata_r;
    logic [7:0]  code_nxt;
    logic [31:0] data_nxt;
    logic        wr_ok;
    logic [31:0] proc_id_word;
    logic [31:0] plat_id_word;
    logic [31:0] thread_word;
    logic [31:0] unit_word;

    ms_tick_gen #(.PERIOD(MS_PERIOD)) u_tick (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .tick_out (ms_tick)
    );

    // ok answer with data
    function automatic logic [39:0] ok(input logic [31:0] d);
        return {pkg_cfg_pkg::CC_OK, d};
    endfunction

    // indices 26..32 take only a zero parameter
    function automatic logic in_service_range(input logic [7:0] idx);
        return idx >= pkg_cfg_pkg::IDX_LIMIT1 && idx <= pkg_cfg_pkg::IDX_THROTTLE_TIME;
    endfunction

    // move a field to its bit position in a 32-bit answer word
    function automatic logic [31:0] place(input logic [31:0] v, input int lsb);
        return v << lsb;
    endfunction

    // fixed answer words; reserved bits stay zero, and the thread count is
    // a product constant so enabling or disabling cores never changes it
    assign proc_id_word = place(32'(STEP_VAL), pkg_cfg_pkg::STEP_LSB)
                        | place(32'(MODEL_VAL), pkg_cfg_pkg::MODEL_LSB)
                        | place(32'(FAMILY_VAL), pkg_cfg_pkg::FAMILY_LSB)
                        | place(32'(TYPE_VAL), pkg_cfg_pkg::TYPE_LSB)
                        | place(32'(EXT_MODEL_VAL), pkg_cfg_pkg::EXT_MODEL_LSB)
                        | place(32'(EXT_FAM_VAL), pkg_cfg_pkg::EXT_FAMILY_LSB); // R7
    assign plat_id_word = 32'(PROC_FLAG); // R8
    assign thread_word  = 32'(THREAD_COUNT); // R9 R10
    assign unit_word    = place(32'(POWER_UNIT), pkg_cfg_pkg::POWER_UNIT_LSB)
                        | place(32'(ENERGY_UNIT), pkg_cfg_pkg::ENERGY_UNIT_LSB)
                        | place(32'(TIME_UNIT), pkg_cfg_pkg::TIME_UNIT_LSB); // R3

    // run time counter, wraps at 32 bits
    // rolls over silently; the host works with differences of two reads
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            run_ms_r <= 32'h0000_0000;
        else if (ms_tick.tick)
            run_ms_r <= run_ms_r + 32'h0000_0001; // R4
    end

    // throttle time, counts ms while throttle circuit active
    // the level is taken only in the tick cycle, so short bursts may be missed
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            throttle_ms_r <= 32'h0000_0000;
        else if (ms_tick.tick && thermal_throttle_circuit)
            throttle_ms_r <= throttle_ms_r + 32'h0000_0001; // R5
    end

    // decode request into completion code and data
    always_comb
    begin
        logic [39:0] r;
        r = {pkg_cfg_pkg::CC_BAD_REQ, 32'h0000_0000}; // R14
        wr_ok = 1'b0;
        if (req_write)
        begin
            // a bad parameter outranks a read-only index inside 26..32
            if (req_param != pkg_cfg_pkg::PARAM_ZERO && in_service_range(req_index))
                r = {pkg_cfg_pkg::CC_BAD_PARAM, 32'h0000_0000}; // R13
            // only the two limits are writable
            else if (req_index == pkg_cfg_pkg::IDX_LIMIT1 || req_index == pkg_cfg_pkg::IDX_LIMIT2)
            begin
                r = ok(32'h0000_0000);
                wr_ok = 1'b1; // R1
            end
        end
        else if (req_index == pkg_cfg_pkg::IDX_PKG_ID)
        begin
            case (req_param) // R6 R11
                pkg_cfg_pkg::PARAM_PROC_ID:
                    r = ok(proc_id_word); // R7
                pkg_cfg_pkg::PARAM_PLATFORM_ID:
                    r = ok(plat_id_word); // R8
                pkg_cfg_pkg::PARAM_THREAD_CNT:
                    r = ok(thread_word); // R9 R10
                pkg_cfg_pkg::PARAM_UCODE_REV:
                    r = ok(UCODE_REV); // R12
                pkg_cfg_pkg::PARAM_ERR_LOG:
                    r = ok(err_src_log);
                default:
                    r = {pkg_cfg_pkg::CC_BAD_PARAM, 32'h0000_0000}; // R13
            endcase
        end
        // reads in 26..32 take only a zero parameter
        else if (req_param != pkg_cfg_pkg::PARAM_ZERO && in_service_range(req_index))
            r = {pkg_cfg_pkg::CC_BAD_PARAM, 32'h0000_0000}; // R13
        else
        begin
            case (req_index)
                pkg_cfg_pkg::IDX_LIMIT1:        r = ok(limit1_r); // R1
                pkg_cfg_pkg::IDX_LIMIT2:        r = ok(limit2_r); // R1
                pkg_cfg_pkg::IDX_SKU_LO:        r = ok(product_power[31:0]); // R2
                pkg_cfg_pkg::IDX_SKU_HI:        r = ok(product_power[63:32]); // R2
                pkg_cfg_pkg::IDX_UNITS:
                    r = ok(unit_word); // R3
                pkg_cfg_pkg::IDX_RUN_TIME:      r = ok(run_ms_r); // R4
                pkg_cfg_pkg::IDX_THROTTLE_TIME: r = ok(throttle_ms_r); // R5
                default:                        r = {pkg_cfg_pkg::CC_BAD_REQ, 32'h0000_0000}; // R14
            endcase
        end
        code_nxt = r[39:32];
        data_nxt = r[31:0];
    end

    // power limits, changed only by accepted writes
    // a refused request never reaches them, so a bad write is harmless
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            limit1_r <= pkg_cfg_pkg::LIMIT_RESET;
            limit2_r <= pkg_cfg_pkg::LIMIT_RESET;
        end
        else if (req_valid && wr_ok)
        begin
            if (req_index == pkg_cfg_pkg::IDX_LIMIT1)
                limit1_r <= req_wdata; // R1
            else
                limit2_r <= req_wdata; // R1
        end
    end

    // registered answer, one cycle after the request
    // code and data hold until the next answer, so a slow host still sees them
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rsp_valid_r <= 1'b0;
            rsp_code_r  <= 8'h00;
            rsp_rdata_r <= 32'h0000_0000;
        end
        else
        begin
            rsp_valid_r <= req_valid;
            if (req_valid)
            begin
                rsp_code_r  <= code_nxt;
                rsp_rdata_r <= data_nxt;
            end
        end
    end

    assign rsp_valid    = rsp_valid_r;
    assign rsp_code     = rsp_code_r;
    assign rsp_rdata    = rsp_rdata_r;
    assign power_limit1 = limit1_r;
    assign power_limit2 = limit2_r;
endmodule // pkg_config_service_decoder

//--- verif/svc_dec_chk.sv
// checker: answer timing, codes and limit updates of the decoder
`timescale 1ns/1ps
module svc_dec_chk (
    // clock, reset and request
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [7:0]  req_index,
    input wire logic [15:0] req_param,
    input wire logic [31:0] req_wdata,
    // answer and state
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_code,
    input wire logic [31:0] rsp_rdata,
    input wire logic [63:0] product_power,
    input wire logic [31:0] power_limit1,
    input wire logic [31:0] power_limit2
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // reads with a zero parameter, and the indices that take one
    wire logic rd0 = req_valid && !req_write && req_param == 16'h0000;
    wire logic cfg = req_index >= 8'h1A && req_index <= 8'h20;
    sequence s_wr1; req_valid && req_write && req_index == 8'h1A && req_param == 16'h0000; endsequence
    sequence s_ok; rsp_valid && rsp_code == pkg_cfg_pkg::CC_OK; endsequence
    property p_ans; req_valid |=> rsp_valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer after request");
    property p_idle; !req_valid |=> !rsp_valid; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_lim1; s_wr1 |=> s_ok ##0 power_limit1 == $past(req_wdata); endproperty
    a_lim1: assert property (p_lim1) else $error("limit one not written");
    property p_lim2;
        req_valid && req_write && req_index == 8'h1B && req_param == 16'h0000 |=> power_limit2 == $past(req_wdata);
    endproperty
    a_lim2: assert property (p_lim2) else $error("limit two not written");
    property p_lo; rd0 && req_index == 8'h1C |=> s_ok ##0 rsp_rdata == $past(product_power[31:0]); endproperty
    a_lo: assert property (p_lo) else $error("power low half wrong");
    property p_hi; rd0 && req_index == 8'h1D |=> s_ok ##0 rsp_rdata == $past(product_power[63:32]); endproperty
    a_hi: assert property (p_hi) else $error("power high half wrong");
    property p_bp;
        req_valid && cfg && req_param != 16'h0000 |=>
            rsp_code == 8'h90 && $stable(power_limit1) && $stable(power_limit2);
    endproperty
    a_bp: assert property (p_bp) else $error("bad parameter not refused");
    property p_bi; req_valid && !cfg && req_index != 8'h00 |=> rsp_code == pkg_cfg_pkg::CC_BAD_REQ; endproperty
    a_bi: assert property (p_bi) else $error("unknown index not refused");
    property p_thr;
        req_valid && !req_write && req_index == 8'h00 && req_param == 16'h0003 |=> s_ok ##0 rsp_rdata[31:4] == 28'h0;
    endproperty
    a_thr: assert property (p_thr) else $error("thread word upper bits set");
endmodule // svc_dec_chk
bind pkg_config_service_decoder svc_dec_chk u_chk (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_write(req_write), .req_index(req_index), .req_param(req_param), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_rdata(rsp_rdata), .product_power(product_power),
    .power_limit1(power_limit1), .power_limit2(power_limit2));

//--- verif/mgmt_host.sv
// partner: management host, one request at a time
`timescale 1ns/1ps
module mgmt_host (
    // clock
    input wire logic         clock,
    // request out
    output logic             req_valid,
    output logic             req_write,
    output logic [7:0]       req_index,
    output logic [15:0]      req_param,
    output logic [31:0]      req_wdata,
    // answer in
    input wire logic         rsp_valid,
    input wire logic [7:0]   rsp_code,
    input wire logic [31:0]  rsp_rdata
);
    // idle lines at time zero
    initial
    begin
        req_valid = 1'b0;
        {req_write, req_index, req_param, req_wdata} = '0;
    end
    // drive one request, then invert the released lines so stale values never match
    task automatic xfer(input logic w, input logic [7:0] i, input logic [15:0] p, input logic [31:0] d,
                        output logic [7:0] c, output logic [31:0] q, output bit to);
        int n;
        @(posedge clock);
        {req_valid, req_write, req_index, req_param, req_wdata} <= {1'b1, w, i, p, d};
        @(posedge clock);
        {req_valid, req_write, req_index, req_param, req_wdata} <= {1'b0, ~w, ~i, ~p, ~d};
        n = 0;
        #1;
        while (rsp_valid !== 1'b1 && n < 4)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        to = n == 4;
        c = rsp_code;
        q = rsp_rdata;
    endtask
endmodule // mgmt_host

//--- verif/pkg_config_service_decoder_test.sv
// testbench: service decoder driven by the host model
`timescale 1ns/1ps
module pkg_config_service_decoder_test;
    logic        clock, sys_rst, req_valid, req_write, rsp_valid, thr;
    logic [7:0]  req_index, rsp_code, code;
    logic [15:0] req_param;
    logic [31:0] req_wdata, rsp_rdata, data, a, pl1, pl2;
    logic [63:0] pw = 64'h1122_3344_5566_7788;
    logic [31:0] elog = 32'hA5A5_0F0F;
    logic [15:0] ip [6] = '{16'h0, 16'h1, 16'h3, 16'h4, 16'h5, 16'h2};
    logic [31:0] ev [6] = '{32'h0004_0321, 32'h1, 32'h8, 32'h1, 32'hA5A5_0F0F, 32'h0};
    bit          to;
    int          fails, checks;
    pkg_config_service_decoder #(.MS_PERIOD(10)) u_dut (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_write(req_write), .req_index(req_index), .req_param(req_param), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_rdata(rsp_rdata), .product_power(pw),
        .thermal_throttle_circuit(thr), .err_src_log(elog), .power_limit1(pl1), .power_limit2(pl2));
    mgmt_host u_host (.clock(clock), .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
        .req_param(req_param), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
        .rsp_rdata(rsp_rdata));
    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // verdict and end of run
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp_data(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_code(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_data(nm, {24'h0, e}, {24'h0, g});
    endtask
    // one request; a missing answer ends the run
    task automatic acc(input logic w, input logic [7:0] i, input logic [15:0] p, input logic [31:0] d);
        u_host.xfer(w, i, p, d, code, data, to);
        if (to)
        begin
            fails++;
            final_report();
        end
    endtask
    task automatic rd(input logic [7:0] i, input logic [15:0] p, input logic [7:0] ec, input logic [31:0] ed);
        acc(1'b0, i, p, 32'h0);
        cmp_code("code", ec, code);
        cmp_data("data", ed, data);
    endtask
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        thr = 1'b0;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        cmp_data("limit1", 32'h0, pl1);
        rd(8'h1A, 16'h0, pkg_cfg_pkg::CC_OK, 32'h0);
        acc(1'b1, 8'h1A, 16'h0, 32'hCAFE_0001);
        acc(1'b1, 8'h1B, 16'h0, 32'h5A5A_0002);
        rd(8'h1B, 16'h0, pkg_cfg_pkg::CC_OK, 32'h5A5A_0002);
        acc(1'b1, 8'h1A, 16'h1, 32'h0);
        cmp_code("bad param", 8'h90, code);
        acc(1'b1, 8'h1D, 16'h1, 32'h0);
        cmp_code("ro bad param", 8'h90, code);
        acc(1'b1, 8'h1C, 16'h0, 32'h0);
        cmp_code("ro write", pkg_cfg_pkg::CC_BAD_REQ, code);
        acc(1'b1, 8'h44, 16'h0, 32'h0);
        cmp_code("bad index", pkg_cfg_pkg::CC_BAD_REQ, code);
        cmp_data("limit1", 32'hCAFE_0001, pl1);
        cmp_data("limit2", 32'h5A5A_0002, pl2);
        rd(8'h05, 16'h0, pkg_cfg_pkg::CC_BAD_REQ, 32'h0);
        rd(8'h1C, 16'h0, pkg_cfg_pkg::CC_OK, pw[31:0]);
        rd(8'h1D, 16'h0, pkg_cfg_pkg::CC_OK, pw[63:32]);
        rd(8'h1E, 16'h0, pkg_cfg_pkg::CC_OK, 32'h000A_1003);
        rd(8'h1E, 16'h1, 8'h90, 32'h0);
        for (int k = 0; k < 6; k++)
            rd(8'h00, ip[k], k < 5 ? pkg_cfg_pkg::CC_OK : 8'h90, ev[k]);
        // requests taken fifty edges apart span exactly five ticks of ten cycles
        acc(1'b0, 8'h1F, 16'h0, 32'h0);
        a = data;
        repeat (48) @(posedge clock);
        acc(1'b0, 8'h1F, 16'h0, 32'h0);
        cmp_data("run ms", 32'h5, data - a);
        acc(1'b0, 8'h20, 16'h0, 32'h0);
        a = data;
        repeat (48) @(posedge clock);
        acc(1'b0, 8'h20, 16'h0, 32'h0);
        cmp_data("idle throttle", a, data);
        // throttle high for about 48 edges; tick phase leaves four or five counts
        @(posedge clock);
        thr <= 1'b1;
        repeat (47) @(posedge clock);
        acc(1'b0, 8'h20, 16'h0, 32'h0);
        cmp_data("throttle ms", 32'h1, {31'h0, data - a >= 4 && data - a <= 6});
        final_report();
    end
endmodule // pkg_config_service_decoder_test
